// ### src/card_cmd_regs.svh
// constant codes and counts shared by both ends of the command link
`ifndef CARD_CMD_REGS_SVH
`define CARD_CMD_REGS_SVH
// ==========================================================
// class and instruction bytes
`define CLA_PLAIN 8'h00
`define CLA_PROP 8'h80
`define INS_CHALLENGE 8'h84
`define INS_GET_DATA 8'hca
`define INS_OPTIONS 8'ha8
`define INS_AUTH 8'h88
`define P1P2_NONE 16'h0000
`define LE_ANY 8'h00
// ==========================================================
// retrievable tags
`define TAG_TXN_CTR 16'h9f36
`define TAG_LAST_ONLINE 16'h9f13
`define TAG_PIN_TRY 16'h9f17
`define TAG_LOG_FMT 16'h9f4f
// ==========================================================
// template and object tags
`define TAG_OPT_TEMPLATE 8'h83
`define TAG_FMT1 8'h80
`define TAG_FMT2 8'h77
`define TAG_PROFILE 8'h82
`define TAG_LOCATOR 8'h94
`define TAG_SDAD 16'h9f4b
`define BER_LONG1 8'h81
`define BER_SHORT_MAX 8'h7f
// ==========================================================
// status words
`define SW_OK 16'h9000
`define SW_BAD_LEN 16'h6700
`define SW_BAD_P1P2 16'h6a86
`define SW_NO_TAG 16'h6a88
`define SW_BAD_INS 16'h6d00
`define SW_BAD_CLA 16'h6e00
// ==========================================================
// sizes and counts
`define CHAL_BYTES 8
`define HDR_BYTES 4
`define CASE2_BYTES 5
`define RSP_LIMIT 256
`define F2_OVERHEAD 7
`define SW_BYTES 2
`define RNG_SEED 64'h5a5a_c3c3_0f0f_9696
`endif

// ### src/card_cmd_pkg.sv
// types shared by both ends of the command link
package card_cmd_pkg;
  // ==========================================================
  // command kinds issued by the terminal end
  typedef enum logic [1:0] {
    K_CHALLENGE,
    K_GET_DATA,
    K_OPTIONS,
    K_AUTH
  } cmd_kind_t;
  // byte on the link
  typedef logic [7:0] byte_t;
endpackage

// ### src/apdu_link_if.sv
// byte stream link between terminal end and card end
`timescale 1ns/1ps
interface apdu_link_if;
  // ==========================================================
  // command stream, terminal to card
  logic cmd_valid;
  logic cmd_ready;
  logic [7:0] cmd_data;
  logic cmd_last;
  // ==========================================================
  // response stream, card to terminal, status word as last two bytes
  logic rsp_valid;
  logic rsp_ready;
  logic [7:0] rsp_data;
  logic rsp_last;
  modport card (
    input cmd_valid, cmd_data, cmd_last, rsp_ready,
    output cmd_ready, rsp_valid, rsp_data, rsp_last
  );
  modport terminal (
    output cmd_valid, cmd_data, cmd_last, rsp_ready,
    input cmd_ready, rsp_valid, rsp_data, rsp_last
  );
endinterface

// ### src/card_end.sv
// card end: command checker and response builder
// Behaviour
// - challenge header 00 84 00 00, Le only
// - challenge answer is eight unpredictable bytes
// - challenge usable only by next command
// - data retrieval is 80 CA tag, Le only
// - four tags: 9F36 9F13 9F17 9F4F
// - retrieval answer carries tag, length, value
// - options command 80 A8 00 00 Lc Le
// - terminal wraps options data in tag 83
// - no options list: tag 83, zero length
// - options command starts transaction, returns profile
// - format one: tag 80, profile then locator
// - format two: tag 77 with profile, locator
// - locator is plain concatenated entry list
// - authentication is 00 88 00 00 Lc Le
// - P1 zero carries no algorithm information
// - terminal builds auth data from list
// - auth format one: tag 80, signed data
// - auth format two: tag 77, signed data
// - auth response stays within 256 bytes
`timescale 1ns/1ps
`include "card_cmd_regs.svh"
module card_end
  import card_cmd_pkg::*;
#(
  parameter int AFL_BYTES = 4,
  parameter int LOG_BYTES = 2,
  parameter int SDAD_BYTES = 128
) (
  // clock, reset, enable
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  // link to terminal
  apdu_link_if.card link,
  // card data sources
  input wire logic [63:0] entropy_i,
  input wire logic [15:0] transaction_counter_i,
  input wire logic [15:0] last_online_ctr_i,
  input wire logic [7:0] pin_try_ctr_i,
  input wire logic [LOG_BYTES*8-1:0] log_format_i,
  input wire logic [15:0] capability_profile_i,
  input wire logic [AFL_BYTES*8-1:0] file_read_locator_i,
  input wire logic [SDAD_BYTES*8-1:0] sdad_i,
  input wire logic format2_i,
  // events and data to card core
  output logic txn_start_o,
  output logic [7:0] auth_byte_o,
  output logic auth_valid_o,
  output logic [63:0] challenge_o,
  output logic challenge_valid_o
);
  // ==========================================================
  // sizes
  // signed data clipped so the format two answer stays in range
  localparam int SDAD_MAX = `RSP_LIMIT - `F2_OVERHEAD;
  localparam int SDAD_N = (SDAD_BYTES > SDAD_MAX) ? SDAD_MAX : SDAD_BYTES;
  localparam int A_W = SDAD_N + `F2_OVERHEAD;
  localparam int B_W = AFL_BYTES + 8;
  localparam int C_W = LOG_BYTES + 3;
  localparam int M1 = (A_W > B_W) ? A_W : B_W;
  localparam int M2 = (M1 > C_W) ? M1 : C_W;
  localparam int RSP_W = M2 + `SW_BYTES;
  localparam int VW = RSP_W * 8;

  typedef enum logic [1:0] {S_RX, S_EVAL, S_TX} state_t;

  // ==========================================================
  // state
  state_t state_q; // receive, evaluate, transmit
  logic [8:0] cnt_q; // command bytes taken
  logic [7:0] cla_q, ins_q, p1_q, p2_q, b4_q; // header and Lc/Le
  logic [7:0] d0_q, d1_q; // first two data bytes
  logic [63:0] rng_q; // free running unpredictable source
  logic pend_q; // challenge issued, not yet consumed
  logic [VW-1:0] shf_q; // response bytes, left aligned
  logic [8:0] left_q; // response bytes still to send
  logic [VW-1:0] v; // built response, right aligned
  logic [8:0] n; // built response length
  logic [15:0] sw; // status word of this command
  logic ok; // command accepted
  logic take; // command byte handshake
  logic hdr_auth; // authentication header legal

  assign take = link.cmd_valid & link.cmd_ready;
  assign link.cmd_ready = ce_i && (state_q == S_RX);
  assign link.rsp_valid = ce_i && (state_q == S_TX) && (left_q != 9'h000);
  assign link.rsp_data = shf_q[VW-1 -: 8];
  assign link.rsp_last = (left_q == 9'h001);
  assign hdr_auth = (cla_q == `CLA_PLAIN) && ({p1_q, p2_q} == `P1P2_NONE);

  // ==========================================================
  // sequencing
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      state_q <= S_RX;
    end else if (ce_i) begin
      unique case (state_q)
        S_RX: begin
          if (take && link.cmd_last) begin
            state_q <= S_EVAL;
          end
        end
        S_EVAL: begin
          state_q <= S_TX;
        end
        S_TX: begin
          if (link.rsp_valid && link.rsp_ready && link.rsp_last) begin
            state_q <= S_RX;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // command capture
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      cnt_q <= 9'h000;
      {cla_q, ins_q, p1_q, p2_q, b4_q, d0_q, d1_q} <= 56'h0;
    end else if (ce_i) begin
      if (state_q == S_EVAL) begin
        cnt_q <= 9'h000;
      end else if (take) begin
        cnt_q <= cnt_q + 9'h001;
        unique case (cnt_q)
          9'h000: cla_q <= link.cmd_data;
          9'h001: ins_q <= link.cmd_data;
          9'h002: p1_q <= link.cmd_data;
          9'h003: p2_q <= link.cmd_data;
          9'h004: b4_q <= link.cmd_data;
          9'h005: d0_q <= link.cmd_data;
          9'h006: d1_q <= link.cmd_data;
          default: ;
        endcase
      end
    end
  end

  // ==========================================================
  // authentication data passed on to the core, Le byte excluded
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      auth_valid_o <= 1'b0;
      auth_byte_o <= 8'h00;
    end else if (ce_i) begin
      auth_valid_o <= take && !link.cmd_last && (ins_q == `INS_AUTH)
                      && hdr_auth && (cnt_q > 9'h004);
      auth_byte_o <= link.cmd_data;
    end
  end

  // ==========================================================
  // unpredictable number source
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      rng_q <= `RNG_SEED;
    end else if (ce_i) begin
      rng_q <= {rng_q[62:0], rng_q[63] ^ rng_q[62] ^ rng_q[60] ^ rng_q[59]}
               ^ entropy_i;
    end
  end

  // ==========================================================
  // challenge lifetime: only the next command may use it
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      pend_q <= 1'b0;
      challenge_valid_o <= 1'b0;
      challenge_o <= 64'h0;
    end else if (ce_i) begin
      if (state_q == S_EVAL && ok && ins_q == `INS_CHALLENGE) begin
        pend_q <= 1'b1;
        challenge_o <= rng_q;
      end else if (take && cnt_q == 9'h000) begin
        challenge_valid_o <= pend_q;
        pend_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // transaction start pulse
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      txn_start_o <= 1'b0;
    end else if (ce_i) begin
      txn_start_o <= (state_q == S_EVAL) && ok
                     && (ins_q == `INS_OPTIONS);
    end
  end

  // ==========================================================
  // append one byte to the built response
  function automatic logic [VW-1:0] push(input logic [VW-1:0] x,
                                         input logic [7:0] b);
    push = {x[VW-9:0], b};
  endfunction

  // ==========================================================
  // check command and build the response bytes
  always_comb begin
    v = '0;
    n = 9'h000;
    sw = `SW_OK;
    unique case (ins_q)
      `INS_CHALLENGE: begin
        if (cla_q != `CLA_PLAIN) sw = `SW_BAD_CLA;
        else if ({p1_q, p2_q} != `P1P2_NONE) sw = `SW_BAD_P1P2;
        else if (cnt_q != 9'(`CASE2_BYTES)) sw = `SW_BAD_LEN;
        else begin
          for (int i = `CHAL_BYTES - 1; i >= 0; i--) begin
            v = push(v, rng_q[i*8 +: 8]);
          end
          n = 9'(`CHAL_BYTES);
        end
      end
      `INS_GET_DATA: begin
        if (cla_q != `CLA_PROP) sw = `SW_BAD_CLA;
        else if (cnt_q != 9'(`CASE2_BYTES)) sw = `SW_BAD_LEN;
        else begin
          v = push(push(v, p1_q), p2_q);
          unique case ({p1_q, p2_q})
            `TAG_TXN_CTR: begin
              v = push(push(push(v, 8'h02), transaction_counter_i[15:8]),
                       transaction_counter_i[7:0]);
              n = 9'h005;
            end
            `TAG_LAST_ONLINE: begin
              v = push(push(push(v, 8'h02), last_online_ctr_i[15:8]),
                       last_online_ctr_i[7:0]);
              n = 9'h005;
            end
            `TAG_PIN_TRY: begin
              v = push(push(v, 8'h01), pin_try_ctr_i);
              n = 9'h004;
            end
            `TAG_LOG_FMT: begin
              v = push(v, 8'(LOG_BYTES));
              for (int i = LOG_BYTES - 1; i >= 0; i--) begin
                v = push(v, log_format_i[i*8 +: 8]);
              end
              n = 9'(LOG_BYTES + 3);
            end
            default: begin
              v = '0;
              sw = `SW_NO_TAG;
            end
          endcase
        end
      end
      `INS_OPTIONS: begin
        if (cla_q != `CLA_PROP) sw = `SW_BAD_CLA;
        else if ({p1_q, p2_q} != `P1P2_NONE) sw = `SW_BAD_P1P2;
        else if (cnt_q != 9'(b4_q) + 9'h006 || b4_q < 8'h02
                 || d0_q != `TAG_OPT_TEMPLATE
                 || d1_q != b4_q - 8'h02) sw = `SW_BAD_LEN;
        else if (!format2_i) begin
          v = push(push(v, `TAG_FMT1), 8'(AFL_BYTES + 2));
          v = push(push(v, capability_profile_i[15:8]),
                   capability_profile_i[7:0]);
          for (int i = AFL_BYTES - 1; i >= 0; i--) begin
            v = push(v, file_read_locator_i[i*8 +: 8]);
          end
          n = 9'(AFL_BYTES + 4);
        end else begin
          v = push(push(v, `TAG_FMT2), 8'(AFL_BYTES + 6));
          v = push(push(v, `TAG_PROFILE), 8'h02);
          v = push(push(v, capability_profile_i[15:8]),
                   capability_profile_i[7:0]);
          v = push(push(v, `TAG_LOCATOR), 8'(AFL_BYTES));
          for (int i = AFL_BYTES - 1; i >= 0; i--) begin
            v = push(v, file_read_locator_i[i*8 +: 8]);
          end
          n = 9'(AFL_BYTES + 8);
        end
      end
      `INS_AUTH: begin
        // P1 zero only: algorithm is implied or inside the data
        if (cla_q != `CLA_PLAIN) sw = `SW_BAD_CLA;
        else if ({p1_q, p2_q} != `P1P2_NONE) sw = `SW_BAD_P1P2;
        else if (cnt_q != 9'(b4_q) + 9'h006) sw = `SW_BAD_LEN;
        else begin
          if (format2_i) begin
            v = push(v, `TAG_FMT2);
            if (SDAD_N + 4 > `BER_SHORT_MAX) v = push(v, `BER_LONG1);
            v = push(v, 8'(SDAD_N + 3 + ((SDAD_N > `BER_SHORT_MAX) ? 1 : 0)));
            v = push(push(v, 8'(`TAG_SDAD >> 8)), 8'(`TAG_SDAD));
          end else begin
            v = push(v, `TAG_FMT1);
          end
          if (SDAD_N > `BER_SHORT_MAX) v = push(v, `BER_LONG1);
          v = push(v, 8'(SDAD_N));
          for (int i = SDAD_N - 1; i >= 0; i--) begin
            v = push(v, sdad_i[(SDAD_BYTES-SDAD_N+i)*8 +: 8]);
          end
          n = 9'(SDAD_N + 2 + ((SDAD_N > `BER_SHORT_MAX) ? 1 : 0)
                 + (format2_i ? 3 + ((SDAD_N + 4 > `BER_SHORT_MAX) ? 1 : 0)
                 : 0));
        end
      end
      default: sw = `SW_BAD_INS;
    endcase
    ok = (sw == `SW_OK);
    v = push(push(v, sw[15:8]), sw[7:0]); // error leaves only the status
    n = n + 9'(`SW_BYTES);
  end

  // ==========================================================
  // response shifter
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      shf_q <= '0;
      left_q <= 9'h000;
    end else if (ce_i) begin
      if (state_q == S_EVAL) begin
        shf_q <= v << ((RSP_W - int'(n)) * 8);
        left_q <= n;
      end else if (link.rsp_valid && link.rsp_ready) begin
        shf_q <= shf_q << 8;
        left_q <= left_q - 9'h001;
      end
    end
  end
endmodule

// ### src/terminal_end.sv
// terminal end: builds command byte streams and returns answers
`timescale 1ns/1ps
`include "card_cmd_regs.svh"
module terminal_end
  import card_cmd_pkg::*;
(
  // clock, reset, enable
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  // link to card
  apdu_link_if.terminal link,
  // request from user
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire cmd_kind_t req_kind_i,
  input wire logic [15:0] req_tag_i,
  input wire logic [7:0] req_len_i,
  // request data bytes (options or authentication data)
  input wire logic dat_valid_i,
  input wire logic [7:0] dat_i,
  output logic dat_ready_o,
  // answer to user
  output logic [7:0] rsp_byte_o,
  output logic rsp_valid_o,
  output logic rsp_last_o,
  output logic [15:0] sw_o,
  output logic done_o
);
  // ==========================================================
  // state
  logic busy_q; // command in flight
  logic sent_q; // all command bytes issued
  cmd_kind_t kind_q; // kind being sent
  logic [15:0] p12_q; // P1 P2
  logic [7:0] len_q; // user data length
  logic [8:0] pos_q; // next byte position
  logic [8:0] tot_q; // total command bytes
  logic ov_q; // output byte held
  logic [7:0] ob_q; // output byte
  logic ol_q; // output byte is last
  logic [7:0] nb; // byte at pos_q
  logic nd; // byte at pos_q comes from user
  logic load; // output register may take a new byte
  logic adv; // pos_q advances

  assign req_ready_o = !busy_q;
  assign link.cmd_valid = ov_q && ce_i;
  assign link.cmd_data = ob_q;
  assign link.cmd_last = ol_q;
  assign link.rsp_ready = ce_i;
  assign load = ce_i && busy_q && !sent_q && (!ov_q || link.cmd_ready);
  assign dat_ready_o = load && nd;
  assign adv = load && (!nd || dat_valid_i);

  // ==========================================================
  // byte at the current position
  always_comb begin
    nd = 1'b0;
    nb = `LE_ANY;
    unique case (pos_q)
      9'h000: nb = (kind_q inside {K_CHALLENGE, K_AUTH})
                   ? `CLA_PLAIN : `CLA_PROP;
      9'h001: begin
        unique case (kind_q)
          K_CHALLENGE: nb = `INS_CHALLENGE;
          K_GET_DATA: nb = `INS_GET_DATA;
          K_OPTIONS: nb = `INS_OPTIONS;
          K_AUTH: nb = `INS_AUTH;
        endcase
      end
      9'h002: nb = p12_q[15:8];
      9'h003: nb = p12_q[7:0];
      default: begin
        if (pos_q == tot_q - 9'h001) nb = `LE_ANY;
        else if (pos_q == 9'h004) nb = (kind_q == K_OPTIONS)
                                      ? len_q + 8'h02 : len_q;
        else if (kind_q == K_OPTIONS && pos_q == 9'h005)
          nb = `TAG_OPT_TEMPLATE;
        else if (kind_q == K_OPTIONS && pos_q == 9'h006)
          nb = len_q;
        else begin
          nd = 1'b1;
          nb = dat_i;
        end
      end
    endcase
  end

  // ==========================================================
  // request intake and byte sequencing
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      busy_q <= 1'b0;
      sent_q <= 1'b0;
      kind_q <= K_CHALLENGE;
      p12_q <= 16'h0000;
      len_q <= 8'h00;
      pos_q <= 9'h000;
      tot_q <= 9'h000;
    end else if (ce_i) begin
      if (!busy_q && req_valid_i) begin
        busy_q <= 1'b1;
        sent_q <= 1'b0;
        kind_q <= req_kind_i;
        pos_q <= 9'h000;
        unique case (req_kind_i)
          K_GET_DATA: p12_q <= req_tag_i;
          default: p12_q <= `P1P2_NONE;
        endcase
        len_q <= req_len_i;
        unique case (req_kind_i)
          K_OPTIONS: tot_q <= 9'(req_len_i) + 9'h008;
          K_AUTH: tot_q <= 9'(req_len_i) + 9'h006;
          default: tot_q <= 9'(`CASE2_BYTES);
        endcase
      end else if (adv) begin
        pos_q <= pos_q + 9'h001;
        sent_q <= (pos_q == tot_q - 9'h001);
      end
      if (busy_q && link.rsp_valid && link.rsp_last) begin
        busy_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // command output register
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      ov_q <= 1'b0;
      ob_q <= 8'h00;
      ol_q <= 1'b0;
    end else if (ce_i) begin
      if (adv) begin
        ov_q <= 1'b1;
        ob_q <= nb;
        ol_q <= (pos_q == tot_q - 9'h001);
      end else if (link.cmd_ready) begin
        ov_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // answer forwarding and status capture
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      rsp_byte_o <= 8'h00;
      rsp_valid_o <= 1'b0;
      rsp_last_o <= 1'b0;
      sw_o <= 16'h0000;
      done_o <= 1'b0;
    end else if (ce_i) begin
      rsp_valid_o <= link.rsp_valid;
      rsp_last_o <= link.rsp_valid && link.rsp_last;
      done_o <= link.rsp_valid && link.rsp_last;
      if (link.rsp_valid) begin
        rsp_byte_o <= link.rsp_data;
        sw_o <= {sw_o[7:0], link.rsp_data};
      end
    end
  end
endmodule

// ### test/apdu_link_props.sv
// checker for the link between terminal end and card end
`timescale 1ns/1ps
module apdu_link_props (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // command stream
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_last,
  // response stream
  input wire logic rsp_valid,
  input wire logic rsp_ready,
  input wire logic [7:0] rsp_data,
  input wire logic rsp_last
);
  // ==========================================================
  // helper state
  logic cmd_hs;
  logic rsp_hs;
  logic [8:0] idx_q; // byte index in command
  logic [8:0] cnt_q; // byte index in answer
  logic [7:0] ins_q; // last instruction byte
  assign cmd_hs = cmd_valid & cmd_ready;
  assign rsp_hs = rsp_valid & rsp_ready;
  // command byte counter
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      idx_q <= 9'h000;
    end else if (cmd_hs) begin
      idx_q <= cmd_last ? 9'h000 : idx_q + 9'h001;
    end
  end
  // answer byte counter
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      cnt_q <= 9'h000;
    end else if (rsp_hs) begin
      cnt_q <= rsp_last ? 9'h000 : cnt_q + 9'h001;
    end
  end
  // instruction capture
  always_ff @(posedge clk_sys_i) begin
    if (cmd_hs && idx_q == 9'h001) begin
      ins_q <= cmd_data;
    end
  end
  // ==========================================================
  // properties
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_b_i);
  property p_hdr_len;
    cmd_hs && cmd_last |-> idx_q >= 9'h004;
  endproperty
  property p_answer_gap;
    cmd_hs && cmd_last |=> !rsp_valid ##1 rsp_valid;
  endproperty
  property p_busy;
    rsp_valid |-> !cmd_ready;
  endproperty
  property p_chal_len;
    rsp_hs && rsp_last && ins_q == 8'h84 |->
      cnt_q == 9'h009 || cnt_q == 9'h001;
  endproperty
  property p_data_tag;
    rsp_hs && cnt_q == 9'h000 && ins_q == 8'hca |->
      rsp_data inside {8'h9f, 8'h6a, 8'h67};
  endproperty
  property p_opt_fmt;
    rsp_hs && cnt_q == 9'h000 && ins_q == 8'ha8 |->
      rsp_data inside {8'h80, 8'h77, 8'h6a, 8'h67};
  endproperty
  property p_auth_fmt;
    rsp_hs && cnt_q == 9'h000 && ins_q == 8'h88 |->
      rsp_data inside {8'h80, 8'h77, 8'h6a, 8'h67};
  endproperty
  property p_auth_limit;
    rsp_valid && ins_q == 8'h88 |-> cnt_q <= 9'h101;
  endproperty
  a_hdr_len: assert property (p_hdr_len)
    else $error("command ended before its header");
  a_answer_gap: assert property (p_answer_gap)
    else $error("answer did not start two cycles after command");
  a_busy: assert property (p_busy)
    else $error("command taken while answering");
  a_chal_len: assert property (p_chal_len)
    else $error("challenge answer length wrong");
  a_data_tag: assert property (p_data_tag)
    else $error("retrieval answer lacks tag");
  a_opt_fmt: assert property (p_opt_fmt)
    else $error("options answer has wrong template");
  a_auth_fmt: assert property (p_auth_fmt)
    else $error("authentication answer has wrong template");
  a_auth_limit: assert property (p_auth_limit)
    else $error("authentication answer too long");
  // main scenarios seen
  c_chal: cover property (rsp_hs && rsp_last && ins_q == 8'h84);
  c_opt: cover property (rsp_hs && rsp_last && ins_q == 8'ha8);
  c_auth: cover property (rsp_hs && rsp_last && ins_q == 8'h88);
endmodule

// ### test/card_command_decoder_bench.sv
// testbench: terminal end and card end joined over the link
`timescale 1ns/1ps
module card_command_decoder_bench;
  import card_cmd_pkg::*;
  // ==========================================================
  // stimulus and card data
  logic clk_sys_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic ce = 1'b1;
  logic req_valid_i = 1'b0;
  cmd_kind_t req_kind_i = K_CHALLENGE;
  logic [15:0] req_tag_i = 16'h0000;
  logic [7:0] req_len_i = 8'h00;
  logic f2_q = 1'b0;
  logic [63:0] ent = 64'h0123_4567_89ab_cdef;
  logic [15:0] ctr = 16'h1234;
  logic [15:0] lon = 16'h5678;
  logic [15:0] logf = 16'habcd;
  logic [15:0] prof = 16'h1c00;
  logic [7:0] pin = 8'h03;
  logic [31:0] file_read_locator = 32'h0801_0100;
  logic [31:0] sd = 32'hdead_beef;
  // design outputs
  logic req_ready_o, dat_ready_o, rsp_valid_o, rsp_last_o, done_o;
  logic [7:0] rsp_byte_o, auth_byte_o;
  logic [15:0] sw_o;
  logic txn_start_o, auth_valid_o, challenge_valid_o;
  logic [63:0] challenge_o, ch;
  // bookkeeping
  int mismatches = 0;
  int total_checks = 0;
  int txn_n = 0;
  int auth_n = 0;
  byte_t got[$], cmd[$], e[$];
  logic [15:0] tg[4] = '{16'h9f36, 16'h9f13, 16'h9f17, 16'h9f4f};
  apdu_link_if link ();
  terminal_end terminal_end_inst (.clk_sys_i, .rst_b_i, .ce_i(ce),
    .link(link.terminal), .req_valid_i, .req_ready_o, .req_kind_i,
    .req_tag_i, .req_len_i, .dat_valid_i(1'b1), .dat_i(8'h5a),
    .dat_ready_o, .rsp_byte_o, .rsp_valid_o, .rsp_last_o, .sw_o,
    .done_o);
  card_end #(.SDAD_BYTES(4)) card_end_inst (
    .clk_sys_i, .rst_b_i, .ce_i(ce), .link(link.card), .entropy_i(ent),
    .transaction_counter_i(ctr), .last_online_ctr_i(lon),
    .pin_try_ctr_i(pin), .log_format_i(logf), .capability_profile_i(prof),
    .file_read_locator_i(file_read_locator), .sdad_i(sd), .format2_i(f2_q),
    .txn_start_o, .auth_byte_o, .auth_valid_o, .challenge_o,
    .challenge_valid_o);
  apdu_link_props apdu_link_props_inst (.clk_sys_i, .rst_b_i,
    .cmd_valid(link.cmd_valid), .cmd_ready(link.cmd_ready),
    .cmd_data(link.cmd_data), .cmd_last(link.cmd_last),
    .rsp_valid(link.rsp_valid), .rsp_ready(link.rsp_ready),
    .rsp_data(link.rsp_data), .rsp_last(link.rsp_last));
  // clock
  initial begin
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end
  // pause inside first command
  initial begin
    repeat (15) @(posedge clk_sys_i);
    ce <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    ce <= 1'b1;
  end
  // answer, command and pulse monitors
  always @(negedge clk_sys_i) begin
    if (rsp_valid_o === 1'b1) got.push_back(rsp_byte_o);
    if (link.cmd_valid && link.cmd_ready) cmd.push_back(link.cmd_data);
    if (txn_start_o === 1'b1) txn_n++;
    if (auth_valid_o === 1'b1) auth_n++;
  end
  // ==========================================================
  // tasks
  task automatic cmp(input logic [63:0] g, input logic [63:0] x);
    total_checks++;
    if (g !== x) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic cmpq(input byte_t g[$], input byte_t x[$]);
    cmp(g.size(), x.size());
    foreach (x[i]) cmp(g[i], x[i]);
  endtask
  task automatic run(input cmd_kind_t k, input logic [15:0] t,
                     input logic [7:0] n, input logic f);
    int i;
    got.delete();
    cmd.delete();
    @(posedge clk_sys_i);
    req_valid_i <= 1'b1;
    req_kind_i <= k;
    req_tag_i <= t;
    req_len_i <= n;
    f2_q <= f;
    @(posedge clk_sys_i);
    req_valid_i <= 1'b0;
    i = 0;
    do begin
      @(negedge clk_sys_i);
      i++;
    end while (done_o !== 1'b1 && i < 2000);
    cmp(done_o, 1'b1);
    @(negedge clk_sys_i);
  endtask
  task automatic note(input string s);
    $display("test %s done, checks=%0d", s, total_checks);
  endtask
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    #20000;
    mismatches++;
    final_report();
  end
  // ==========================================================
  // tests
  initial begin
    repeat (12) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    run(K_CHALLENGE, 16'h0000, 8'h00, 1'b0);
    cmpq(cmd, '{8'h00, 8'h84, 8'h00, 8'h00, 8'h00});
    cmp(got.size(), 10);
    for (int i = 0; i < 8; i++) ch = {ch[55:0], got[i]};
    cmp(challenge_o, ch);
    cmp(sw_o, 16'h9000);
    note("challenge");
    for (int j = 0; j < 4; j++) begin
      run(K_GET_DATA, tg[j], 8'h00, 1'b0);
      cmp(challenge_valid_o, j == 0);
      cmpq(cmd, '{8'h80, 8'hca, tg[j][15:8], tg[j][7:0], 8'h00});
      e = '{tg[j][15:8], tg[j][7:0]};
      case (j)
        0: e = {e, 8'h02, ctr[15:8], ctr[7:0]};
        1: e = {e, 8'h02, lon[15:8], lon[7:0]};
        2: e = {e, 8'h01, pin};
        default: e = {e, 8'h02, logf[15:8], logf[7:0]};
      endcase
      cmpq(got, {e, 8'h90, 8'h00});
    end
    run(K_GET_DATA, 16'h9f99, 8'h00, 1'b0);
    cmpq(got, '{8'h6a, 8'h88});
    note("retrieval");
    run(K_OPTIONS, 16'h0000, 8'h00, 1'b0);
    cmpq(cmd, '{8'h80, 8'ha8, 8'h00, 8'h00, 8'h02, 8'h83, 8'h00,
      8'h00});
    cmpq(got, '{8'h80, 8'h06, prof[15:8], prof[7:0], file_read_locator[31:24],
      file_read_locator[23:16], file_read_locator[15:8], file_read_locator[7:0], 8'h90, 8'h00});
    run(K_OPTIONS, 16'h0000, 8'h02, 1'b1);
    cmpq(cmd, '{8'h80, 8'ha8, 8'h00, 8'h00, 8'h04, 8'h83, 8'h02, 8'h5a,
      8'h5a, 8'h00});
    cmpq(got, '{8'h77, 8'h0a, 8'h82, 8'h02, prof[15:8], prof[7:0], 8'h94,
      8'h04, file_read_locator[31:24], file_read_locator[23:16], file_read_locator[15:8], file_read_locator[7:0], 8'h90,
      8'h00});
    cmp(txn_n, 2);
    note("options");
    run(K_AUTH, 16'h0000, 8'h02, 1'b1);
    cmpq(cmd, '{8'h00, 8'h88, 8'h00, 8'h00, 8'h02, 8'h5a, 8'h5a,
      8'h00});
    cmpq(got, '{8'h77, 8'h07, 8'h9f, 8'h4b, 8'h04, sd[31:24], sd[23:16],
      sd[15:8], sd[7:0], 8'h90, 8'h00});
    run(K_AUTH, 16'h0000, 8'h02, 1'b0);
    cmpq(got, '{8'h80, 8'h04, sd[31:24], sd[23:16], sd[15:8], sd[7:0],
      8'h90, 8'h00});
    cmp(auth_n, 4);
    note("authentication");
    final_report();
  end
endmodule
